// ---- core/clt_pkg.sv ----
// shared constants and types for the configurable logic tile
// assumes one fabric clock and a synchronous active-low reset
package clt_pkg;

    // number of tile inputs and lookup width
    localparam int unsigned TILE_INPUTS = 4;
    localparam int unsigned LUT_INPUTS = 3;
    localparam int unsigned LUT_DEPTH = 8;

    // tile input positions used by the sequential modes
    localparam int unsigned POS_DATA = 0;
    localparam int unsigned POS_GATE = 1;
    localparam int unsigned POS_ENABLE = 2;
    localparam int unsigned POS_SC_PLAIN = 2;
    localparam int unsigned POS_SC_ENABLED = 3;

    // values after reset
    localparam logic RST_STORED = 1'b0;
    localparam logic RST_OUT = 1'b0;
    localparam logic RST_GATE_PREV = 1'b0;
    localparam logic [TILE_INPUTS-1:0] RST_SYNC = 4'h0;

    // lookup contents for a few common functions, lookup address {c,b,a}
    localparam logic [LUT_DEPTH-1:0] LUT_INVERT_A = 8'h55;
    localparam logic [LUT_DEPTH-1:0] LUT_AND2 = 8'h88;
    localparam logic [LUT_DEPTH-1:0] LUT_NAND2 = 8'h77;
    localparam logic [LUT_DEPTH-1:0] LUT_OR2 = 8'hee;
    localparam logic [LUT_DEPTH-1:0] LUT_NOR2 = 8'h11;
    localparam logic [LUT_DEPTH-1:0] LUT_XOR2 = 8'h66;
    localparam logic [LUT_DEPTH-1:0] LUT_AND3 = 8'h80;
    localparam logic [LUT_DEPTH-1:0] LUT_XOR3 = 8'h96;
    localparam logic [LUT_DEPTH-1:0] LUT_MAJORITY_OF_THREE = 8'he8;
    // a=first, b=second, c=select: select high passes b
    localparam logic [LUT_DEPTH-1:0] LUT_TWO_WAY_SELECT = 8'hca;

    // tile operating modes
    typedef enum logic [1:0] {
        CLT_MODE_COMB = 2'b00,
        CLT_MODE_LATCH = 2'b01,
        CLT_MODE_DFF = 2'b10,
        CLT_MODE_DFF_ENABLED = 2'b11
    } clt_mode_type;

endpackage : clt_pkg

// ---- core/clt_tile_if.sv ----
// carries the conditioned tile inputs from the input stage to the tile core
// assumes both ends run on the same fabric clock
interface clt_tile_if;
    logic [3:0] pin;

    modport source (output pin);
    modport sink (input pin);
endinterface : clt_tile_if

// ---- core/clt_input_stage.sv ----
// input stage: two-flop synchroniser and per-input polarity inversion
// assumes raw tile inputs come from outside the clock domain
module clt_input_stage #(
    parameter int unsigned WIDTH = 4
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // raw inputs and polarity configuration
    input wire logic [WIDTH-1:0] raw_in,
    input wire logic [WIDTH-1:0] invert_mask,
    // conditioned inputs
    clt_tile_if.source conditioned
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] stable_reg;
    logic [WIDTH-1:0] stable_next;

    // second flop only reads the first
    always_comb begin
        meta_next = raw_in;
        stable_next = meta_reg;
        if (!reset_n) begin
            meta_next = clt_pkg::RST_SYNC;
            stable_next = clt_pkg::RST_SYNC;
        end
    end

    // register synchroniser stages
    always_ff @(posedge clock) begin
        meta_reg <= meta_next;
        stable_reg <= stable_next;
    end

    // inversion absorbed into the tile, no external inverter needed
    assign conditioned.pin = stable_reg ^ invert_mask;

endmodule : clt_input_stage

// ---- core/clt_tile.sv ----
// configurable logic tile: lookup, latch, flip-flop and enabled flip-flop modes
// assumes configuration inputs are static and come from the fabric clock domain
// assumes the set/clear input of the enabled flip-flop arrives on a global net

// How it works
// - four inputs; combinational mode computes any function of three selected inputs
// - latch mode follows data while gate is high, with selectable clear or set
// - flip-flop mode captures data on gate rising edge, with clear or set
// - enabled flip-flop takes its set or clear on the fourth input
// - each input has its own configurable polarity inversion
// - result goes out on a local output and a separate long-line output
// - eight-entry lookup covers every three-input function, majority and select included
// - sequential modes take one data input; clear or preset takes effect on the next clock edge
module clt_tile (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // tile inputs from routing
    input wire logic [3:0] tile_in,
    // configuration switches
    input wire clt_pkg::clt_mode_type cfg_mode,
    input wire logic [7:0] cfg_truth,
    input wire logic [1:0] cfg_sel_a,
    input wire logic [1:0] cfg_sel_b,
    input wire logic [1:0] cfg_sel_c,
    input wire logic [3:0] cfg_invert,
    input wire logic cfg_sc_used,
    input wire logic cfg_sc_is_set,
    // outputs toward routing
    output logic local_out,
    output logic longline_out,
    output logic stored_value_out
);

    clt_tile_if cond_bus ();

    // synchronise and invert the tile inputs
    clt_input_stage #(
        .WIDTH(clt_pkg::TILE_INPUTS)
    ) u_input_stage (
        .clock(clock),
        .reset_n(reset_n),
        .raw_in(tile_in),
        .invert_mask(cfg_invert),
        .conditioned(cond_bus.source)
    );

    // picks one of the four inputs by a configured index
    function automatic logic pick_input(input logic [3:0] pins, input logic [1:0] sel);
        logic bit_value;
        bit_value = pins[sel];
        return bit_value;
    endfunction : pick_input

    // looks up a three-input function in an eight-entry table
    function automatic logic lut_eval(input logic [7:0] table_bits, input logic [2:0] addr);
        logic bit_value;
        bit_value = table_bits[addr];
        return bit_value;
    endfunction : lut_eval

    logic [3:0] pins;
    logic [2:0] lut_addr;
    logic lut_result;
    logic data_in;
    logic gate_in;
    logic enable_in;
    logic sc_in;
    logic sc_active;
    logic gate_rise;

    logic stored_reg;
    logic stored_next;
    logic gate_prev_reg;
    logic gate_prev_next;
    logic local_reg;
    logic local_next;
    logic longline_reg;
    logic longline_next;

    assign pins = cond_bus.pin;

    // lookup address from three configurable inputs
    always_comb begin
        lut_addr[0] = pick_input(pins, cfg_sel_a);
        lut_addr[1] = pick_input(pins, cfg_sel_b);
        lut_addr[2] = pick_input(pins, cfg_sel_c);
        lut_result = lut_eval(cfg_truth, lut_addr);
    end

    // fixed roles of the inputs in the sequential modes
    always_comb begin
        data_in = pins[clt_pkg::POS_DATA];
        gate_in = pins[clt_pkg::POS_GATE];
        enable_in = pins[clt_pkg::POS_ENABLE];
        if (cfg_mode == clt_pkg::CLT_MODE_DFF_ENABLED) begin
            sc_in = pins[clt_pkg::POS_SC_ENABLED];
        end else begin
            sc_in = pins[clt_pkg::POS_SC_PLAIN];
        end
        sc_active = cfg_sc_used && sc_in;
        gate_rise = gate_in && !gate_prev_reg;
    end

    // next stored value by mode; clear or preset wins over gate and enable, reset wins over all
    always_comb begin
        stored_next = stored_reg;
        gate_prev_next = gate_in;
        case (cfg_mode)
            clt_pkg::CLT_MODE_COMB: begin
                stored_next = stored_reg;
            end
            clt_pkg::CLT_MODE_LATCH: begin
                if (sc_active) begin
                    stored_next = cfg_sc_is_set;
                end else if (gate_in) begin
                    stored_next = data_in;
                end
            end
            clt_pkg::CLT_MODE_DFF: begin
                if (sc_active) begin
                    stored_next = cfg_sc_is_set;
                end else if (gate_rise) begin
                    stored_next = data_in;
                end
            end
            clt_pkg::CLT_MODE_DFF_ENABLED: begin
                if (sc_active) begin
                    stored_next = cfg_sc_is_set;
                end else if (gate_rise && enable_in) begin
                    stored_next = data_in;
                end
            end
            default: begin
                stored_next = stored_reg;
            end
        endcase
        if (!reset_n) begin
            stored_next = clt_pkg::RST_STORED;
            gate_prev_next = clt_pkg::RST_GATE_PREV;
        end
    end

    // both outputs carry the same result
    always_comb begin
        if (cfg_mode == clt_pkg::CLT_MODE_COMB) begin
            local_next = lut_result;
        end else begin
            local_next = stored_next;
        end
        longline_next = local_next;
        if (!reset_n) begin
            local_next = clt_pkg::RST_OUT;
            longline_next = clt_pkg::RST_OUT;
        end
    end

    // register tile state and outputs
    always_ff @(posedge clock) begin
        stored_reg <= stored_next;
        gate_prev_reg <= gate_prev_next;
        local_reg <= local_next;
        longline_reg <= longline_next;
    end

    assign local_out = local_reg;
    assign longline_out = longline_reg;
    assign stored_value_out = stored_reg;

endmodule : clt_tile

// ---- verif/clt_tile_monitor.sv ----
// checker for the logic tile, bound to its ports
// assumes configuration only changes while reset_n is low
module clt_tile_monitor (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // tile inputs and configuration
    input wire logic [3:0] tile_in,
    input wire clt_pkg::clt_mode_type cfg_mode,
    input wire logic [7:0] cfg_truth,
    input wire logic [1:0] cfg_sel_a,
    input wire logic [1:0] cfg_sel_b,
    input wire logic [1:0] cfg_sel_c,
    input wire logic [3:0] cfg_invert,
    input wire logic cfg_sc_used,
    input wire logic cfg_sc_is_set,
    // tile outputs
    input wire logic local_out,
    input wire logic longline_out,
    input wire logic stored_value_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] tap_reg;
    logic [2:0] up_reg;
    logic [3:0] now_c;
    logic [3:0] old_c;
    logic ok, sc, rise, is_lat, is_ff, is_en, is_seq;

    // pin history and settled count after reset
    always_ff @(posedge clock) begin
        tap_reg <= {tap_reg[11:0], tile_in};
        up_reg <= !reset_n ? 3'h0 : up_reg + {2'h0, up_reg != 3'h7};
    end

    // pins as the tile saw them for the sampled output
    // sampled output stems from the pins three edges back: two sync flops, one output flop
    assign now_c = tap_reg[11:8] ^ cfg_invert;
    assign old_c = tap_reg[15:12] ^ cfg_invert;
    assign ok = up_reg == 3'h7;
    assign is_lat = cfg_mode == clt_pkg::CLT_MODE_LATCH;
    assign is_ff = cfg_mode == clt_pkg::CLT_MODE_DFF;
    assign is_en = cfg_mode == clt_pkg::CLT_MODE_DFF_ENABLED;
    assign is_seq = cfg_mode != clt_pkg::CLT_MODE_COMB;
    assign sc = cfg_sc_used && (is_en ? now_c[3] : now_c[2]);
    assign rise = now_c[1] && !old_c[1];

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    a_comb_lookup: assert property (ok && !is_seq |->
        local_out == cfg_truth[{now_c[cfg_sel_c], now_c[cfg_sel_b], now_c[cfg_sel_a]}])
        else $error("lookup output wrong");
    a_long_same: assert property (ok |-> longline_out == local_out)
        else $error("long output differs");
    a_seq_stored: assert property (ok && is_seq |-> local_out == stored_value_out)
        else $error("output not stored bit");
    a_sc_forces: assert property (ok && is_seq && sc |->
        stored_value_out == cfg_sc_is_set) else $error("set or clear ignored");
    a_latch_follows: assert property (ok && is_lat && !sc && now_c[1] |->
        stored_value_out == now_c[0]) else $error("latch not transparent");
    a_dff_capture: assert property (ok && is_ff && !sc && rise |->
        stored_value_out == now_c[0]) else $error("flop missed capture");
    a_dff_holds: assert property (ok && is_ff && !sc && !rise |->
        $stable(stored_value_out)) else $error("flop changed off edge");
    a_enable_holds: assert property (ok && is_en && !sc && !now_c[2] |->
        $stable(stored_value_out)) else $error("disabled flop changed");
    a_enable_capture: assert property (ok && is_en && !sc && now_c[2] && rise |->
        stored_value_out == now_c[0]) else $error("enabled flop missed capture");
endmodule : clt_tile_monitor

bind clt_tile clt_tile_monitor u_monitor (
    .clock(clock),
    .reset_n(reset_n),
    .tile_in(tile_in),
    .cfg_mode(cfg_mode),
    .cfg_truth(cfg_truth),
    .cfg_sel_a(cfg_sel_a),
    .cfg_sel_b(cfg_sel_b),
    .cfg_sel_c(cfg_sel_c),
    .cfg_invert(cfg_invert),
    .cfg_sc_used(cfg_sc_used),
    .cfg_sc_is_set(cfg_sc_is_set),
    .local_out(local_out),
    .longline_out(longline_out),
    .stored_value_out(stored_value_out)
);

// ---- verif/tb.sv ----
// self-checking bench for the logic tile, one task per scenario
// assumes pins reach the outputs three clock edges after sampling
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    `define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_errors++; \
        $display("CHECK FAILED at %0t got %h exp %h", $time, g, e); end end
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic [3:0] tile_in = 4'h0;
    clt_pkg::clt_mode_type cfg_mode = clt_pkg::CLT_MODE_COMB;
    logic [7:0] cfg_truth = 8'h00;
    logic [1:0] cfg_sel_a = 2'h0, cfg_sel_b = 2'h1, cfg_sel_c = 2'h2;
    logic [3:0] cfg_invert = 4'h0;
    logic cfg_sc_used = 1'b0, cfg_sc_is_set = 1'b0;
    logic local_out, longline_out, stored_value_out;
    int n_errors = 0, checks = 0, cycles = 0;

    clt_tile DUT (
        .clock(clock),
        .reset_n(reset_n),
        .tile_in(tile_in),
        .cfg_mode(cfg_mode),
        .cfg_truth(cfg_truth),
        .cfg_sel_a(cfg_sel_a),
        .cfg_sel_b(cfg_sel_b),
        .cfg_sel_c(cfg_sel_c),
        .cfg_invert(cfg_invert),
        .cfg_sc_used(cfg_sc_used),
        .cfg_sc_is_set(cfg_sc_is_set),
        .local_out(local_out),
        .longline_out(longline_out),
        .stored_value_out(stored_value_out)
    );

    // clock and hang guard
    always #12.5 clock = ~clock;
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        if (n_errors == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up

    task automatic tick();
        @(posedge clock);
        #1;
    endtask : tick

    // reset with a fresh configuration, selection a=0 b=1 c=2 unless changed after
    task automatic setup(clt_pkg::clt_mode_type m, logic [7:0] t, logic [3:0] i, logic u, logic s);
        reset_n = 1'b0;
        tile_in = 4'h0;
        cfg_mode = m;
        cfg_truth = t;
        cfg_invert = i;
        cfg_sc_used = u;
        cfg_sc_is_set = s;
        repeat (5) tick();
        reset_n = 1'b1;
    endtask : setup

    // drive the pins, then compare all three outputs once the pipeline settles
    task automatic look(logic [3:0] v, logic e);
        tile_in = v;
        repeat (4) tick();
        `CHK(local_out, e)
        `CHK(longline_out, e)
        `CHK(stored_value_out, (cfg_mode == clt_pkg::CLT_MODE_COMB) ? clt_pkg::RST_STORED : e)
    endtask : look

    // every listed function over all input combinations
    task automatic t_comb();
        logic [7:0] tt [10] = '{clt_pkg::LUT_INVERT_A, clt_pkg::LUT_AND2, clt_pkg::LUT_NAND2,
            clt_pkg::LUT_OR2, clt_pkg::LUT_NOR2, clt_pkg::LUT_XOR2, clt_pkg::LUT_AND3,
            clt_pkg::LUT_XOR3, clt_pkg::LUT_MAJORITY_OF_THREE, clt_pkg::LUT_TWO_WAY_SELECT};
        logic a, b, c, e;
        for (int k = 0; k < 10; k++) begin
            setup(clt_pkg::CLT_MODE_COMB, tt[k], 4'h0, 1'b0, 1'b0);
            for (int v = 0; v < 8; v++) begin
                {c, b, a} = v[2:0];
                case (k)
                    0: e = !a;
                    1: e = a & b;
                    2: e = !(a & b);
                    3: e = a | b;
                    4: e = !(a | b);
                    5: e = a ^ b;
                    6: e = a & b & c;
                    7: e = a ^ b ^ c;
                    8: e = (a & b) | (a & c) | (b & c);
                    default: e = c ? b : a;
                endcase
                look({1'b0, v[2:0]}, e);
            end
        end
    endtask : t_comb

    // other pins selected, one of them inverted inside the tile
    task automatic t_invert();
        setup(clt_pkg::CLT_MODE_COMB, clt_pkg::LUT_AND2, 4'h8, 1'b0, 1'b0);
        cfg_sel_a = 2'h3;
        look(4'h2, 1'b1);
        look(4'ha, 1'b0);
        cfg_sel_a = 2'h0;
    endtask : t_invert

    // latch transparency, hold and clear
    task automatic t_latch();
        setup(clt_pkg::CLT_MODE_LATCH, 8'h00, 4'h0, 1'b1, 1'b0);
        look(4'h3, 1'b1);
        look(4'h0, 1'b1);
        look(4'h2, 1'b0);
        look(4'h1, 1'b0);
        look(4'h3, 1'b1);
        look(4'h7, 1'b0);
    endtask : t_latch

    // edge capture, hold with gate high, synchronous preset
    task automatic t_dff();
        setup(clt_pkg::CLT_MODE_DFF, 8'h00, 4'h0, 1'b1, 1'b1);
        look(4'h1, 1'b0);
        look(4'h3, 1'b1);
        look(4'h0, 1'b1);
        look(4'h2, 1'b0);
        look(4'h3, 1'b0);
        look(4'h4, 1'b1);
    endtask : t_dff

    // enable gates capture, clear on fourth pin overrides it
    task automatic t_enable();
        setup(clt_pkg::CLT_MODE_DFF_ENABLED, 8'h00, 4'h8, 1'b1, 1'b0);
        look(4'h9, 1'b0);
        look(4'hb, 1'b0);
        look(4'hd, 1'b0);
        look(4'hf, 1'b1);
        look(4'h7, 1'b0);
    endtask : t_enable

    initial begin
        t_comb();
        t_invert();
        t_latch();
        t_dff();
        t_enable();
        wrap_up();
    end
endmodule : tb
